// file: shared/ffc_pkg.sv
// Constants, register map and carrier types of the FFSK checksum and transmit sequencing block
package ffc_pkg;
  // Timing
  localparam int unsigned FFC_CLK_HZ = 40_000_000;
  localparam int unsigned FFC_BAUD = 1200;
  localparam int unsigned FFC_BIT_CYCLES = FFC_CLK_HZ / FFC_BAUD;
  // Register byte addresses
  localparam logic [7:0] FFC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] FFC_ADDR_TXDATA = 8'h04;
  localparam logic [7:0] FFC_ADDR_STATUS = 8'h08;
  localparam logic [7:0] FFC_ADDR_MASK = 8'h0c;
  localparam logic [7:0] FFC_ADDR_RESIDUE = 8'h10;
  localparam logic [7:0] FFC_ADDR_RXDATA = 8'h14;
  // Status and mask bit positions
  localparam int unsigned FFC_ST_TXREQ = 0;
  localparam int unsigned FFC_ST_TXIDLE = 1;
  localparam int unsigned FFC_ST_RXPASS = 2;
  localparam int unsigned FFC_ST_RXDONE = 3;
  localparam int unsigned FFC_ST_W = 4;
  // Checksum geometry
  localparam logic [14:0] FFC_POLY = 15'h6815;
  localparam logic [5:0] FFC_MSG_BITS = 6'h30;
  localparam logic [5:0] FFC_RX_INV_BIT = 6'h3e;
  localparam logic [5:0] FFC_RX_PAR_BIT = 6'h3f;
  localparam logic [4:0] FFC_BYTE_LEN = 5'h08;
  localparam logic [4:0] FFC_CHECK_LEN = 5'h10;
  // Reset values and bus answers
  localparam logic [3:0] FFC_MASK_RESET = 4'h0;
  localparam logic [1:0] FFC_RESP_OKAY = 2'h0;
  localparam logic [1:0] FFC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic csum_en;
    logic rx_en;
    logic tx_en;
  } ffc_ctrl_type;

  typedef struct packed {
    logic rx_done;
    logic rx_pass;
    logic tx_idle;
    logic tx_req;
  } ffc_status_type;

  typedef enum logic [3:0] {
    FFC_TX_OFF = 4'b0001,
    FFC_TX_BIAS = 4'b0010,
    FFC_TX_SEND = 4'b0100,
    FFC_TX_HANG = 4'b1000
  } ffc_tx_state_type;
endpackage

// file: logic/ffc_checksum_tx.sv
// FFSK modem checksum generator and checker with transmit sequencing and AXI4-Lite registers
`timescale 1ns/100ps
// Overview of operation
// (RULE1) Transmit divider takes the 48 message bits of 6 bytes by the generator polynomial.
// (RULE2) The 15-bit transmit remainder has its final bit inverted.
// (RULE3) Even parity covers the 48 message bits and the modified remainder.
// (RULE4) Check word is the modified remainder then the parity bit, 16 bits.
// (RULE5) Receive divides the first 63 bits, bit 63 inverted, by the same polynomial.
// (RULE6) Receive tests the 15 remaining divider bits for all zero.
// (RULE7) Receive parity over the first 63 bits is compared with bit 64.
// (RULE8) Check-pass is set only for zero remainder and matching parity.
// (RULE9) Transmit output is released (not driven) while the transmitter is disabled.
// (RULE10) After the hang bit, with transmit still enabled, output sits at bias.
// (RULE11) Buffer-request event is suppressed at the last byte if its flag is already set.
// (RULE12) Transmit-drained event is raised one bit period after the final byte.
// (RULE13) Host keeps checksum insertion low while loading frame word bytes.
// (RULE14) Power-save only when both receive and transmit are disabled.
// (RULE15) With insertion enabled a 2-byte check word follows every 6 message bytes.
// (RULE16) Receive residue: 15 divider bits plus a parity-mismatch bit, readable.
// (RULE17) Bits enter divider and parity MSB first; both restart at each message boundary.
module ffc_checksum_tx
  import ffc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = ffc_pkg::FFC_BIT_CYCLES
) (
  input wire logic core_clk, // System clock, 40 MHz
  input wire logic nrst, // Asynchronous reset, active low
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic rx_bit, // Demodulated receive bit
  input wire logic rx_bit_valid, // One-cycle strobe per received bit
  output logic tx_out, // Transmit bit level
  output logic tx_oe, // Transmit output driven
  output logic tx_bias, // Transmit output held at bias level
  output logic power_save, // Power-save request
  output logic irq // Interrupt, active high
);
  import ffc_pkg::*;

  function automatic logic [14:0] ffc_div_step(input logic [14:0] rem, input logic din);
    logic fb;
    fb = din ^ rem[14];
    ffc_div_step = {rem[13:0], 1'b0} ^ (fb ? FFC_POLY : 15'h0000);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Reset synchroniser
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register bus
  ffc_ctrl_type ctrl;
  ffc_status_type status;
  logic [3:0] mask;
  logic [15:0] residue;
  logic [7:0] rx_data;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_go;
  logic rd_go;
  logic tx_write;
  logic status_read;
  logic [31:0] rd_word;
  logic rd_ok;

  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign rd_go = s_axi_arvalid && s_axi_arready;
  assign tx_write = wr_go && aw_addr == FFC_ADDR_TXDATA && w_strb[0];
  assign status_read = rd_go && s_axi_araddr == FFC_ADDR_STATUS;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= FFC_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr == FFC_ADDR_CTRL || aw_addr == FFC_ADDR_TXDATA || aw_addr == FFC_ADDR_MASK)
          ? FFC_RESP_OKAY : FFC_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= '0;
      mask <= FFC_MASK_RESET;
    end else if (wr_go && w_strb[0]) begin
      if (aw_addr == FFC_ADDR_CTRL) begin
        ctrl <= w_data[2:0];
      end
      if (aw_addr == FFC_ADDR_MASK) begin
        mask <= w_data[3:0];
      end
    end
  end

  always_comb begin
    rd_ok = 1'b1;
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      FFC_ADDR_CTRL: rd_word = {29'h0000_0000, ctrl};
      FFC_ADDR_STATUS: rd_word = {28'h000_0000, status};
      FFC_ADDR_MASK: rd_word = {28'h000_0000, mask};
      FFC_ADDR_RESIDUE: rd_word = {16'h0000, residue};
      FFC_ADDR_RXDATA: rd_word = {24'h00_0000, rx_data};
      FFC_ADDR_TXDATA: rd_word = 32'h0000_0000;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= FFC_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_ok ? FFC_RESP_OKAY : FFC_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmit sequencing and checksum generation
  ffc_tx_state_type tx_state;
  logic [15:0] bit_cnt;
  logic tick;
  logic [7:0] tx_buf;
  logic tx_buf_full;
  logic tx_buf_csum;
  logic tx_req_flag;
  logic [15:0] tx_sh;
  logic [4:0] tx_left;
  logic tx_cur_csum;
  logic [14:0] tx_rem;
  logic tx_par;
  logic [5:0] tx_msg_bits;
  logic [14:0] next_rem;
  logic [14:0] check_rem;
  logic check_par;
  logic feed;
  logic last_msg_bit;
  logic ev_tx_req;
  logic ev_tx_idle;

  assign tick = bit_cnt == 16'(BIT_CYCLES - 1);
  assign feed = tx_state == FFC_TX_SEND && tick && tx_cur_csum;
  assign next_rem = ffc_div_step(tx_rem, tx_sh[15]); // RULE1 RULE17
  assign check_rem = {next_rem[14:1], ~next_rem[0]}; // RULE2
  assign check_par = tx_par ^ tx_sh[15] ^ (^check_rem); // RULE3
  assign last_msg_bit = feed && tx_msg_bits == FFC_MSG_BITS - 6'h01;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt <= 16'h0000;
    end else if (!ctrl.tx_en || tick) begin
      bit_cnt <= 16'h0000;
    end else begin
      bit_cnt <= bit_cnt + 16'h0001;
    end
  end

  // Host buffer; insertion enable is captured with each byte so frame words stay out
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_buf <= 8'h00;
      tx_buf_full <= 1'b0;
      tx_buf_csum <= 1'b0;
    end else if (!ctrl.tx_en) begin
      tx_buf_full <= 1'b0;
    end else if (tx_write) begin
      tx_buf <= w_data[7:0];
      tx_buf_full <= 1'b1;
      tx_buf_csum <= ctrl.csum_en; // RULE13
    end else if (tick && tx_left == 5'h01 && tx_state == FFC_TX_SEND && !last_msg_bit) begin
      tx_buf_full <= 1'b0;
    end else if (tick && tx_state == FFC_TX_BIAS) begin
      tx_buf_full <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_state <= FFC_TX_OFF;
      tx_sh <= 16'h0000;
      tx_left <= 5'h00;
      tx_cur_csum <= 1'b0;
      tx_req_flag <= 1'b0;
      ev_tx_req <= 1'b0;
      ev_tx_idle <= 1'b0;
    end else begin
      ev_tx_req <= 1'b0;
      ev_tx_idle <= 1'b0;
      if (tx_write) begin
        tx_req_flag <= 1'b0;
      end
      unique case (tx_state)
        FFC_TX_OFF: begin
          if (ctrl.tx_en) begin
            tx_state <= FFC_TX_BIAS;
            tx_req_flag <= 1'b1;
          end
        end
        FFC_TX_BIAS: begin
          if (tick && tx_buf_full) begin
            tx_state <= FFC_TX_SEND;
            tx_sh <= {tx_buf, 8'h00};
            tx_left <= FFC_BYTE_LEN;
            tx_cur_csum <= tx_buf_csum;
            tx_req_flag <= 1'b1;
            ev_tx_req <= 1'b1;
          end
        end
        FFC_TX_SEND: begin
          if (tick) begin
            tx_sh <= {tx_sh[14:0], 1'b0};
            tx_left <= tx_left - 5'h01;
            if (last_msg_bit && tx_left == 5'h01) begin
              tx_sh <= {check_rem, check_par}; // RULE4 RULE15
              tx_left <= FFC_CHECK_LEN;
              tx_cur_csum <= 1'b0;
            end else if (tx_left == 5'h01) begin
              if (tx_buf_full) begin
                tx_sh <= {tx_buf, 8'h00};
                tx_left <= FFC_BYTE_LEN;
                tx_cur_csum <= tx_buf_csum;
                tx_req_flag <= 1'b1;
                ev_tx_req <= 1'b1;
              end else begin
                tx_state <= FFC_TX_HANG;
                ev_tx_req <= !tx_req_flag; // RULE11
                tx_req_flag <= 1'b1;
              end
            end
          end
        end
        FFC_TX_HANG: begin
          if (tick) begin
            tx_state <= FFC_TX_BIAS;
            ev_tx_idle <= 1'b1; // RULE12
          end
        end
        default: tx_state <= FFC_TX_OFF;
      endcase
      if (!ctrl.tx_en) begin
        tx_state <= FFC_TX_OFF;
        tx_req_flag <= 1'b0;
      end
    end
  end

  // Divider and parity restart after each message of 48 counted bits
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_rem <= 15'h0000;
      tx_par <= 1'b0;
      tx_msg_bits <= 6'h00;
    end else if (!ctrl.tx_en || last_msg_bit) begin
      tx_rem <= 15'h0000; // RULE17
      tx_par <= 1'b0;
      tx_msg_bits <= 6'h00;
    end else if (feed) begin
      tx_rem <= next_rem; // RULE1
      tx_par <= tx_par ^ tx_sh[15]; // RULE3
      tx_msg_bits <= tx_msg_bits + 6'h01;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_out <= 1'b1;
      tx_oe <= 1'b0;
      tx_bias <= 1'b0;
    end else begin
      tx_oe <= tx_state != FFC_TX_OFF; // RULE9
      tx_bias <= tx_state == FFC_TX_BIAS; // RULE10
      tx_out <= tx_state == FFC_TX_SEND ? tx_sh[15] : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receive checker
  logic [5:0] rx_idx;
  logic [14:0] rx_rem;
  logic rx_par;
  logic [7:0] rx_sh;
  logic rx_mid;
  logic rx_perr;
  logic ev_rx_done;
  logic ev_rx_pass;

  assign rx_mid = rx_bit_valid && ctrl.rx_en;
  assign rx_perr = rx_par ^ rx_bit; // RULE7

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_idx <= 6'h00;
      rx_rem <= 15'h0000;
      rx_par <= 1'b0;
      rx_sh <= 8'h00;
      rx_data <= 8'h00;
      residue <= 16'h0000;
      ev_rx_done <= 1'b0;
      ev_rx_pass <= 1'b0;
    end else begin
      ev_rx_done <= 1'b0;
      ev_rx_pass <= 1'b0;
      if (!ctrl.rx_en) begin
        rx_idx <= 6'h00;
        rx_rem <= 15'h0000;
        rx_par <= 1'b0;
      end else if (rx_mid) begin
        rx_sh <= {rx_sh[6:0], rx_bit};
        if (rx_idx[2:0] == 3'h7) begin
          rx_data <= {rx_sh[6:0], rx_bit};
        end
        rx_idx <= rx_idx + 6'h01;
        if (rx_idx == FFC_RX_PAR_BIT) begin
          residue <= {rx_perr, rx_rem}; // RULE16
          ev_rx_done <= 1'b1;
          ev_rx_pass <= rx_rem == 15'h0000 && !rx_perr; // RULE6 RULE8
          rx_rem <= 15'h0000; // RULE17
          rx_par <= 1'b0;
        end else begin
          rx_rem <= ffc_div_step(rx_rem, rx_idx == FFC_RX_INV_BIT ? ~rx_bit : rx_bit); // RULE5
          rx_par <= rx_par ^ rx_bit; // RULE7
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, interrupt and power-save
  ffc_status_type st_set;
  assign st_set = {ev_rx_done, ev_rx_pass, ev_tx_idle, ev_tx_req};

  // Set wins over the clear-on-read
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= '0;
      irq <= 1'b0;
      power_save <= 1'b0;
    end else begin
      status <= (status_read ? ffc_status_type'(4'h0) : status) | st_set;
      irq <= |(status & mask);
      power_save <= !ctrl.tx_en && !ctrl.rx_en && tx_state == FFC_TX_OFF; // RULE14
    end
  end
endmodule

// file: test/ffc_checksum_tx_sva.sv
// Port assertions of the checksum and transmit block
`timescale 1ns/100ps
module ffc_checksum_tx_sva
  import ffc_pkg::*;
#(
  parameter int unsigned BIT_CYCLES = ffc_pkg::FFC_BIT_CYCLES
) (
  input wire logic core_clk, // Clock
  input wire logic nrst, // Reset
  input wire logic [7:0] s_axi_awaddr, // AW addr
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic [31:0] s_axi_wdata, // W data
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic [7:0] s_axi_araddr, // AR addr
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R resp
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic tx_out, // Tx level
  input wire logic tx_oe, // Tx driven
  input wire logic tx_bias, // Tx bias
  input wire logic power_save // Power save
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  logic [31:0] run;
  logic prev;
  logic wr_ctrl;
  assign wr_ctrl = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_awaddr == FFC_ADDR_CTRL;
  ////////////////////////////////////////
  // Cycles the transmit level has held
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      run <= 32'h0;
      prev <= 1'b1;
    end else begin
      prev <= tx_out;
      run <= tx_bias ? 32'h0 : (tx_out != prev) ? 32'h1 : run + 32'h1;
    end
  end
  ////////////////////////////////////////
  a_bias_driven: assert property (tx_bias |-> tx_oe && tx_out)
    else $error("bias state not driven high");
  a_save_idle: assert property (power_save |-> !tx_oe)
    else $error("power save while transmitting");
  a_save_enter: assert property (wr_ctrl && s_axi_wdata[1:0] == 2'h0 |-> ##[1:4] power_save)
    else $error("power save not entered");
  a_tx_release: assert property (wr_ctrl && !s_axi_wdata[0] |-> ##[1:4] !tx_oe)
    else $error("transmit output not released");
  a_bit_period: assert property (tx_out != prev && !tx_bias |-> run % BIT_CYCLES == 0)
    else $error("bit length off");
  a_write_answer: assert property (wr_ctrl |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_unmapped_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > FFC_ADDR_RXDATA
    |=> s_axi_rresp == FFC_RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read answered");
endmodule
bind ffc_checksum_tx ffc_checksum_tx_sva #(.BIT_CYCLES(BIT_CYCLES)) ffc_checksum_tx_sva_i (.core_clk, .nrst,
  .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .tx_out, .tx_oe, .tx_bias, .power_save);

// file: test/ffc_host.sv
// Host processor model driving the register bus
`timescale 1ns/100ps
module ffc_host (
  input wire logic core_clk, // Clock
  output logic [7:0] s_axi_awaddr, // AW addr
  output logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  output logic [31:0] s_axi_wdata, // W data
  output logic [3:0] s_axi_wstrb, // W strobes
  output logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic [1:0] s_axi_bresp, // B resp
  output logic s_axi_bready, // B ready
  output logic [7:0] s_axi_araddr, // AR addr
  output logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic [31:0] s_axi_rdata, // R data
  input wire logic [1:0] s_axi_rresp, // R resp
  input wire logic s_axi_rvalid, // R valid
  output logic s_axi_rready // R ready
);
  logic [1:0] bresp_seen;
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  ////////////////////////////////////////
  // Answers are accepted one edge late, so the slave must hold them
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge core_clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    @(posedge core_clk);
    bresp_seen = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    s_axi_rready <= 1'b1;
    @(posedge core_clk);
    d = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// file: test/ffc_checksum_tx_bench.sv
// Bench: transmit stream, receive check and registers against a queue model
`timescale 1ns/100ps
module ffc_checksum_tx_bench;
  import ffc_pkg::*;
  localparam int unsigned BC = 8;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic rx_bit = 1'b0;
  logic rx_bit_valid = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_rresp, s_axi_bresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic tx_out, tx_oe, tx_bias, power_save, irq;
  int fail_count = 0;
  int checked = 0;
  int cyc = 0;
  int ph = 0;
  logic txq[$];
  logic exp[$];
  ffc_checksum_tx #(.BIT_CYCLES(BC)) ffc_checksum_tx_i (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rx_bit, .rx_bit_valid, .tx_out, .tx_oe, .tx_bias, .power_save, .irq);
  ffc_host ffc_host_i (.core_clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  always #12.5 core_clk = ~core_clk;
  ////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  function automatic logic [14:0] divide(input logic q[$], input int n);
    logic [14:0] rem;
    rem = 15'h0;
    for (int i = 0; i < n; i++) rem = {rem[13:0], 1'b0} ^ ((q[i] ^ rem[14]) ? FFC_POLY : 15'h0);
    return rem;
  endfunction
  task automatic send_rx(input logic r[$]);
    foreach (r[i]) begin
      @(posedge core_clk);
      rx_bit <= r[i];
      rx_bit_valid <= 1'b1;
      @(posedge core_clk);
      rx_bit_valid <= 1'b0;
    end
  endtask
  ////////////////////////////////////////
  // Line sampled mid bit while sending
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      fail_count++;
      end_of_test();
    end
    if (tx_oe && !tx_bias) begin
      if (ph == BC / 2) txq.push_back(tx_out);
      ph <= (ph + 1) % BC;
    end else begin
      ph <= 0;
    end
  end
  initial begin
    logic [31:0] d;
    logic [1:0] resp;
    logic [7:0] b;
    logic m[$];
    logic r[$];
    logic [15:0] res;
    logic [14:0] rem;
    logic par;
    int k;
    k = $urandom(26480);
    repeat (6) @(posedge core_clk);
    nrst <= 1'b1;
    repeat (4) @(posedge core_clk);
    check("reset pins", 32'({power_save, tx_oe}), 32'h2);
    ffc_host_i.rd(FFC_ADDR_MASK, d, resp);
    check("mask reset", d, 32'(FFC_MASK_RESET));
    ffc_host_i.wr(FFC_ADDR_MASK, 32'h2);
    check("mask write resp", 32'(ffc_host_i.bresp_seen), 32'(FFC_RESP_OKAY));
    ffc_host_i.wr(FFC_ADDR_CTRL, 32'h1);
    ffc_host_i.rd(FFC_ADDR_STATUS, d, resp);
    for (int i = 0; i < 8; i++) begin
      if (i == 2) ffc_host_i.wr(FFC_ADDR_CTRL, 32'h5);
      b = 8'($urandom);
      for (int j = 7; j >= 0; j--) begin
        exp.push_back(b[j]);
        if (i >= 2) m.push_back(b[j]);
      end
      ffc_host_i.wr(FFC_ADDR_TXDATA, {24'h0, b});
      do ffc_host_i.rd(FFC_ADDR_STATUS, d, resp); while (!d[FFC_ST_TXREQ]);
    end
    rem = divide(m, 48);
    rem[0] = ~rem[0];
    par = ^rem;
    foreach (m[i]) par ^= m[i];
    for (int j = 14; j >= 0; j--) exp.push_back(rem[j]);
    exp.push_back(par);
    exp.push_back(1'b1);
    k = 0;
    while (!irq && k < 4000) begin
      @(posedge core_clk);
      k++;
    end
    check("stream length", txq.size(), exp.size());
    foreach (exp[i]) check("tx bit", 32'(txq[i]), 32'(exp[i]));
    check("bias after hang", 32'({tx_oe, tx_bias, tx_out}), 32'h7);
    ffc_host_i.rd(FFC_ADDR_STATUS, d, resp);
    check("idle status", d & 32'h3, 32'h2);
    ffc_host_i.rd(FFC_ADDR_STATUS, d, resp);
    check("status cleared", d & 32'h2, 32'h0);
    check("irq cleared", 32'(irq), 32'h0);
    ffc_host_i.wr(FFC_ADDR_CTRL, 32'h2);
    repeat (4) @(posedge core_clk);
    check("released", 32'({tx_oe, power_save}), 32'h0);
    for (int t = 0; t < 4; t++) begin
      r = exp[16:79];
      k = (t == 0) ? -1 : (t == 1) ? 63 : (t == 2) ? 62 : $urandom_range(61, 0);
      if (k >= 0) r[k] = ~r[k];
      send_rx(r);
      m = r[0:62];
      m[62] = ~m[62];
      par = 1'b0;
      for (int i = 0; i < 63; i++) par ^= r[i];
      for (int i = 56; i < 64; i++) b = {b[6:0], r[i]};
      res = {par ^ r[63], divide(m, 63)};
      ffc_host_i.rd(FFC_ADDR_RESIDUE, d, resp);
      check("residue", d, {16'h0, res});
      ffc_host_i.rd(FFC_ADDR_STATUS, d, resp);
      check("rx status", d & 32'hc, (res == 16'h0) ? 32'hc : 32'h8);
      ffc_host_i.rd(FFC_ADDR_RXDATA, d, resp);
      check("rx byte", d, {24'h0, b});
    end
    ffc_host_i.rd(FFC_ADDR_CTRL, d, resp);
    check("ctrl readback", d, 32'h2);
    ffc_host_i.rd(8'h18, d, resp);
    check("unmapped resp", {30'h0, resp}, {30'h0, FFC_RESP_SLVERR});
    check("unmapped data", d, 32'h0);
    ffc_host_i.wr(8'h18, 32'h1);
    check("unmapped write resp", 32'(ffc_host_i.bresp_seen), 32'(FFC_RESP_SLVERR));
    ffc_host_i.wr(FFC_ADDR_CTRL, 32'h0);
    repeat (4) @(posedge core_clk);
    check("power save entered", 32'(power_save), 32'h1);
    end_of_test();
  end
endmodule
